/* core/adc_startup_chop_sequencer.sv */
// Start-up, reset command and global-chop sequencer with AXI4-Lite registers
`timescale 1ns/100ps
module adc_startup_chop_sequencer #(
  parameter int POR_CYCLES       = 2048,
  parameter int RESET_LOW_CYCLES = 256
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        master_clock_input,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  input  wire logic        sync_reset_n,
  input  wire logic [23:0] raw_result,
  output logic             conversion_ready_n,
  output logic [23:0]      conv_result,
  output logic             fast_filter_sel,
  output logic             modulator_run,
  output logic             chop_polarity,
  output logic             filter_reset,
  output logic [1:0]       power_mode_select,
  output logic [7:0]       phase_delay_0,
  output logic [7:0]       phase_delay_1,
  output logic             dc_test_valid
);

  function automatic logic [19:0] ratio_len(input logic [2:0] code);
    ratio_len = adc_seq_pkg::RATIO_BASE << code;
  endfunction

  function automatic logic [19:0] delay_len(input logic [3:0] code);
    delay_len = adc_seq_pkg::DELAY_BASE << code;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction

  // Pin synchronisers: mclk, sclk, cs_n, din, sync_n
  logic [4:0] sy1_r;
  logic [4:0] sy2_r;
  logic [4:0] sy3_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sy1_r <= 5'h07;
      sy2_r <= 5'h07;
      sy3_r <= 5'h07;
    end else begin
      sy1_r <= {master_clock_input, sclk, cs_n, din, sync_reset_n};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
    end
  end

  logic mod_tick;
  logic sclk_fall;
  logic cs_s;
  logic din_s;
  logic sync_s;
  logic sync_fall;
  assign mod_tick  = sy2_r[4] && !sy3_r[4];
  assign sclk_fall = !sy2_r[3] && sy3_r[3];
  assign cs_s      = sy2_r[2];
  assign din_s     = sy2_r[1];
  assign sync_s    = sy2_r[0];
  assign sync_fall = !sy2_r[0] && sy3_r[0];

  adc_seq_pkg::seq_state_t state_r;
  logic [31:0] ctrl_r;
  logic [15:0] phase_r;

  logic        chop_en;
  logic [3:0]  delay_code;
  logic [2:0]  ratio_code;
  assign chop_en    = ctrl_r[adc_seq_pkg::CHOP_EN_BIT];
  assign delay_code = ctrl_r[adc_seq_pkg::DELAY_LSB +: 4];
  assign ratio_code = ctrl_r[adc_seq_pkg::RATIO_LSB +: 3];

  // Serial frame: only the reset command is decoded here
  logic [6:0]  bit_cnt_r;
  logic [15:0] cmd_r;
  logic        cmd_fire;
  assign cmd_fire = (state_r != adc_seq_pkg::st_por) && !cs_s && sclk_fall
                 && bit_cnt_r == adc_seq_pkg::FRAME_BITS - 7'd1
                 && cmd_r == adc_seq_pkg::RESET_CMD;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_cnt_r <= 7'd0;
      cmd_r     <= 16'h0000;
    end else if (cs_s) begin
      bit_cnt_r <= 7'd0;
    end else if (sclk_fall && bit_cnt_r != adc_seq_pkg::FRAME_BITS) begin
      bit_cnt_r <= bit_cnt_r + 7'd1;
      if (bit_cnt_r < 7'd16) begin
        cmd_r <= {cmd_r[14:0], din_s};
      end
    end
  end

  // Sync pin low for longer than the reset width holds the device
  logic [15:0] sync_low_r;
  logic        pin_hold;
  assign pin_hold = sync_low_r >= 16'(RESET_LOW_CYCLES);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_low_r <= 16'd0;
    end else if (sync_s) begin
      sync_low_r <= 16'd0;
    end else if (!pin_hold) begin
      sync_low_r <= sync_low_r + 16'd1;
    end
  end

  logic soft_reset;
  assign soft_reset = cmd_fire || pin_hold;

  logic [2:0] ratio_prev_r;
  logic       restart;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ratio_prev_r <= adc_seq_pkg::CTRL_RST[adc_seq_pkg::RATIO_LSB +: 3];
    end else begin
      ratio_prev_r <= ratio_code;
    end
  end
  assign restart = chop_en && state_r == adc_seq_pkg::st_conv
                && (sync_fall || ratio_code != ratio_prev_r);

  logic [19:0] first_len;
  logic [19:0] chop_len;
  assign chop_len  = delay_len(delay_code)
                   + 20'(3 * ratio_len(ratio_code));
  assign first_len = chop_len + chop_len + adc_seq_pkg::FIRST_EXTRA;

  logic [19:0] cnt_r;
  logic [19:0] len_r;
  logic [1:0]  samples_r;
  logic        period_end;
  assign period_end = state_r == adc_seq_pkg::st_conv && !restart
                   && mod_tick && cnt_r == len_r - 20'd1;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r   <= adc_seq_pkg::st_por;
      cnt_r     <= 20'd0;
      len_r     <= 20'd0;
      samples_r <= 2'd0;
    end else if (pin_hold) begin
      state_r   <= adc_seq_pkg::st_hold;
      cnt_r     <= 20'd0;
      samples_r <= 2'd0;
    end else if (cmd_fire) begin
      state_r   <= adc_seq_pkg::st_modwait;
      cnt_r     <= 20'd0;
      samples_r <= 2'd0;
    end else begin
      unique case (state_r)
        adc_seq_pkg::st_por: begin
          if (cnt_r == 20'(POR_CYCLES - 1)) begin
            state_r <= adc_seq_pkg::st_modwait;
            cnt_r   <= 20'd0;
          end else begin
            cnt_r <= cnt_r + 20'd1;
          end
        end
        adc_seq_pkg::st_hold: begin
          if (sync_s) begin
            state_r <= adc_seq_pkg::st_modwait;
          end
        end
        adc_seq_pkg::st_modwait: begin
          if (mod_tick) begin
            if (cnt_r == adc_seq_pkg::MOD_WAIT - 20'd1) begin
              state_r <= adc_seq_pkg::st_conv;
              cnt_r   <= 20'd0;
              len_r   <= chop_en ? first_len : ratio_len(ratio_code);
            end else begin
              cnt_r <= cnt_r + 20'd1;
            end
          end
        end
        adc_seq_pkg::st_conv: begin
          if (restart) begin
            cnt_r <= 20'd0;
            len_r <= first_len;
          end else if (period_end) begin
            cnt_r <= 20'd0;
            len_r <= chop_en ? chop_len : ratio_len(ratio_code);
            if (samples_r != adc_seq_pkg::FAST_SAMPLES) begin
              samples_r <= samples_r + 2'd1;
            end
          end else if (mod_tick) begin
            cnt_r <= cnt_r + 20'd1;
          end
        end
      endcase
    end
  end

  assign modulator_run   = state_r == adc_seq_pkg::st_conv;
  assign fast_filter_sel = samples_r < adc_seq_pkg::FAST_SAMPLES;

  // Polarity swap and filter reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chop_polarity <= 1'b0;
      filter_reset  <= 1'b0;
    end else begin
      filter_reset <= soft_reset || restart
                   || (period_end && chop_en);
      if (soft_reset || restart || !chop_en) begin
        chop_polarity <= 1'b0;
      end else if (period_end) begin
        chop_polarity <= !chop_polarity;
      end
    end
  end

  // Result path: sliding average of the last two conversions in chop mode
  logic [23:0] prev_r;
  logic [24:0] pair_sum;
  assign pair_sum = {prev_r[23], prev_r} + {raw_result[23], raw_result};
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_r      <= 24'h000000;
      conv_result <= 24'h000000;
    end else if (period_end) begin
      prev_r      <= raw_result;
      conv_result <= chop_en ? pair_sum[24:1] : raw_result;
    end
  end

  // Data-ready: low through power-on settling, then low pulse per result
  logic [3:0] ready_cnt_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      conversion_ready_n <= 1'b0;
      ready_cnt_r        <= 4'd0;
    end else if (state_r == adc_seq_pkg::st_por || soft_reset) begin
      conversion_ready_n <= state_r != adc_seq_pkg::st_por
                         || cnt_r == 20'(POR_CYCLES - 1);
      ready_cnt_r        <= 4'd0;
    end else if (period_end) begin
      conversion_ready_n <= 1'b0;
      ready_cnt_r        <= adc_seq_pkg::RDY_LOW_CYC - 4'd1;
    end else if (ready_cnt_r != 4'd0) begin
      ready_cnt_r <= ready_cnt_r - 4'd1;
    end else begin
      conversion_ready_n <= 1'b1;
    end
  end

  assign power_mode_select = ctrl_r[adc_seq_pkg::POWER_LSB +: 2];
  assign phase_delay_0 = chop_en ? 8'h00 : phase_r[7:0];
  assign phase_delay_1 = chop_en ? 8'h00 : phase_r[15:8];
  assign dc_test_valid = ctrl_r[adc_seq_pkg::DCTEST_BIT] && !chop_en;

  // AXI4-Lite write channel
  logic        aw_ok_r;
  logic        w_ok_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        do_write;
  assign awready  = !aw_ok_r && !bvalid;
  assign wready   = !w_ok_r && !bvalid;
  assign do_write = aw_ok_r && w_ok_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_ok_r  <= 1'b0;
      w_ok_r   <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= adc_seq_pkg::AXI_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_ok_r  <= 1'b1;
        awaddr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_ok_r  <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (do_write) begin
        aw_ok_r <= 1'b0;
        w_ok_r  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= (awaddr_r == adc_seq_pkg::OFS_CTRL
                 || awaddr_r == adc_seq_pkg::OFS_PHASE)
                 ? adc_seq_pkg::AXI_OKAY : adc_seq_pkg::AXI_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_r  <= adc_seq_pkg::CTRL_RST;
      phase_r <= adc_seq_pkg::PHASE_RST;
    end else if (soft_reset) begin
      ctrl_r  <= adc_seq_pkg::CTRL_RST;
      phase_r <= adc_seq_pkg::PHASE_RST;
    end else if (do_write && awaddr_r == adc_seq_pkg::OFS_CTRL) begin
      ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r) & 32'h0001_73f1;
    end else if (do_write && awaddr_r == adc_seq_pkg::OFS_PHASE) begin
      phase_r <= 16'(merge({16'h0000, phase_r}, wdata_r, wstrb_r));
    end
  end

  // AXI4-Lite read channel
  logic [31:0] status_w;
  assign status_w = {24'h000000, dc_test_valid, state_r != adc_seq_pkg::st_por,
                     samples_r, chop_polarity, fast_filter_sel, state_r};
  assign arready = !rvalid;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= adc_seq_pkg::AXI_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= adc_seq_pkg::AXI_OKAY;
      unique case (araddr)
        adc_seq_pkg::OFS_CTRL:   rdata <= ctrl_r;
        adc_seq_pkg::OFS_STATUS: rdata <= status_w;
        adc_seq_pkg::OFS_PHASE:  rdata <= {16'h0000, phase_r};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= adc_seq_pkg::AXI_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // Tick counter used only by the modulator-wait check below
  logic [19:0] wait_ticks_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_ticks_r <= 20'd0;
    end else if (state_r != adc_seq_pkg::st_modwait || soft_reset) begin
      wait_ticks_r <= 20'd0;
    end else if (mod_tick) begin
      wait_ticks_r <= wait_ticks_r + 20'd1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_ready_por_low: assert property (
    state_r == adc_seq_pkg::st_por ##1 state_r == adc_seq_pkg::st_modwait
    |-> conversion_ready_n && $past(conversion_ready_n) == 1'b0)
    else $error("data ready did not rise at end of settling");
  a_cmd_reset_act: assert property (
    cmd_fire |=> state_r == adc_seq_pkg::st_modwait
             && ctrl_r == adc_seq_pkg::CTRL_RST && samples_r == 2'd0)
    else $error("reset command did not restart with defaults");
  a_frame_full_only: assert property (
    cmd_fire |-> !cs_s && bit_cnt_r == 7'd95 && !$past(cs_s))
    else $error("reset acted on an incomplete frame");
  a_mod_wait_len: assert property (
    $past(state_r) == adc_seq_pkg::st_modwait
    && state_r == adc_seq_pkg::st_conv |-> wait_ticks_r == 20'd300)
    else $error("modulator wait was not 300 periods");
  a_fast_two_only: assert property (
    period_end && samples_r == 2'd1 |=> !fast_filter_sel)
    else $error("fast path still selected after two samples");
  a_ready_pulse_low: assert property (
    disable iff (rst || soft_reset)
    period_end && !soft_reset |=> (!conversion_ready_n) [*8]
    ##1 conversion_ready_n)
    else $error("data ready pulse has wrong width");
  a_chop_swap_rst: assert property (
    period_end && chop_en && !soft_reset
    |=> filter_reset && chop_polarity != $past(chop_polarity))
    else $error("chop swap missing polarity flip or filter reset");
  a_chop_first_len: assert property (
    restart && !soft_reset |=> cnt_r == 20'd0
    && len_r == $past(first_len))
    else $error("chop restart did not load first period");
  a_phase_bypass: assert property (
    chop_en |-> phase_delay_0 == 8'h00 && phase_delay_1 == 8'h00
             && !dc_test_valid)
    else $error("phase delay or dc test active in chop mode");
  a_pin_hold_stay: assert property (
    pin_hold |=> state_r == adc_seq_pkg::st_hold)
    else $error("pin reset did not hold device");

  c_cmd_reset: cover property (cmd_fire);
  c_chop_restart: cover property (restart && sync_fall);
  c_sinc3_sample: cover property (period_end && samples_r == 2'd2);
  c_pin_reset: cover property (pin_hold ##1 !pin_hold);

endmodule

/* core/adc_seq_pkg.sv */
// Constants and types for the start-up and global-chop sequencer
// How it works
// - Reset command 0011h in word one acts only after the whole frame.
// - Chip select rising before the frame completes drops a pending reset.
// - A frame is exactly four words for both host and device.
// - Latched reset acts at once; conversions follow once defaults load.
// - Data-ready goes low to high when power-on settling ends.
// - Modulators wait 300 modulator periods after clock starts.
// - Modulator feeds both filters; fast settles in one, sinc3 in three.
// - First two samples come from fast path, later ones from sinc3.
// - Command or pin reset skips power-on settling, keeps 300-period wait.
// - Default ratio gives 1024 period, first data 1324, sinc3 3372.
// - Continuous mode converts nonstop at modulator rate over ratio.
// - Chop mode alternates polarity; output averages the latest pair.
// - Each polarity swap resets the filter; three conversions per result.
// - A 4-bit delay field adds 2 to 65,536 periods after swaps.
// - Chop period is delay plus three times ratio; falling edge marks it.
// - Chop restarts on sync pin falling edge or ratio change.
// - First chop period after restart is 2 delays, 6 ratios plus 44.
// - Chop mode ignores phase calibration and applies no phase delay.
// - DC test input gives no valid measurement in chop mode.
// - 2-bit power mode field picks one of three modes in both modes.
// - Data-ready is active low and flags new conversion data.
// - Sync pin low past the reset width resets until it returns high.
// - Every reset source restores register defaults before converting.
package adc_seq_pkg;

  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_STATUS   = 8'h04;
  localparam logic [7:0]  OFS_PHASE    = 8'h08;

  localparam int          CHOP_EN_BIT  = 0;
  localparam int          DELAY_LSB    = 4;
  localparam int          POWER_LSB    = 8;
  localparam int          RATIO_LSB    = 12;
  localparam int          DCTEST_BIT   = 16;
  localparam logic [31:0] CTRL_RST     = 32'h0000_3200;
  localparam logic [15:0] PHASE_RST    = 16'h0000;

  localparam logic [15:0] RESET_CMD    = 16'h0011;
  localparam int          WORD_BITS    = 24;
  localparam int          FRAME_WORDS  = 4;
  localparam logic [6:0]  FRAME_BITS   = 7'(WORD_BITS * FRAME_WORDS);

  localparam logic [19:0] MOD_WAIT     = 20'd300;
  localparam logic [19:0] FIRST_EXTRA  = 20'd44;
  localparam logic [19:0] RATIO_BASE   = 20'd128;
  localparam logic [19:0] DELAY_BASE   = 20'd2;
  localparam logic [1:0]  FAST_SAMPLES = 2'd2;

  localparam int          CLK_NS       = 8;
  localparam int          RDY_LOW_NS   = 64;
  localparam logic [3:0]  RDY_LOW_CYC  = 4'(RDY_LOW_NS / CLK_NS);

  localparam logic [1:0]  AXI_OKAY     = 2'b00;
  localparam logic [1:0]  AXI_SLVERR   = 2'b10;

  typedef enum logic [1:0] {
    very_low_power_mode  = 2'b00,
    low_power_mode       = 2'b01,
    high_resolution_mode = 2'b10
  } power_mode_t;

  typedef enum logic [1:0] {
    st_por,
    st_hold,
    st_modwait,
    st_conv
  } seq_state_t;

endpackage

/* sim/adc_host_model.sv */
// Host serial port model that sends command frames to the sequencer
`timescale 1ns/100ps
module adc_host_model (
  input  wire logic clock,
  output logic      sclk,
  output logic      cs_n,
  output logic      din
);
  localparam int HALF = 10;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b1;
  end

  // Command in the top of word one; fewer than 96 bits cuts the frame short
  task automatic frame(input logic [15:0] cmd, input int nbits);
    logic [95:0] bits;
    bits = {cmd, 8'h00, 72'h0};
    @(posedge clock);
    cs_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      repeat (HALF) @(posedge clock);
      sclk <= 1'b1;
      din  <= bits[95-i];
      repeat (HALF) @(posedge clock);
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge clock);
    cs_n <= 1'b1;
    din  <= ~din;
  endtask
endmodule

/* sim/adc_startup_chop_sequencer_tb.sv */
// Self-checking bench for the start-up and global-chop sequencer
`timescale 1ns/100ps
module adc_startup_chop_sequencer_tb;
  localparam int POR = 20;
  localparam int REG_WAIT = 20;
  logic        clock, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        master_clock_input, sclk, cs_n, din, sync_reset_n;
  logic        conversion_ready_n, fast_filter_sel, modulator_run;
  logic        chop_polarity, filter_reset, dc_test_valid, p;
  logic [7:0]  awaddr, araddr, phase_delay_0, phase_delay_1;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, power_mode_select;
  logic [23:0] raw_result, conv_result;
  int          n_errors = 0, checks = 0, tick = 0, cyc = 0;
  int          t0, t1, t2, c0;

  adc_startup_chop_sequencer #(.POR_CYCLES(POR), .RESET_LOW_CYCLES(8)) DUT (
    .clock(clock), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .master_clock_input(master_clock_input), .sclk(sclk), .cs_n(cs_n),
    .din(din), .sync_reset_n(sync_reset_n), .raw_result(raw_result),
    .conversion_ready_n(conversion_ready_n), .conv_result(conv_result),
    .fast_filter_sel(fast_filter_sel), .modulator_run(modulator_run),
    .chop_polarity(chop_polarity), .filter_reset(filter_reset),
    .power_mode_select(power_mode_select), .phase_delay_0(phase_delay_0),
    .phase_delay_1(phase_delay_1), .dc_test_valid(dc_test_valid));

  adc_host_model HOST (.clock(clock), .sclk(sclk), .cs_n(cs_n), .din(din));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    master_clock_input = 1'b0;
    #13;
    forever #24 master_clock_input = ~master_clock_input;
  end
  always @(posedge master_clock_input) tick <= tick + 1;
  always @(posedge clock) cyc <= cyc + 1;

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_n(input string n, input int e, input int g);
    checks++;
    if (g < e - 2 || g > e + 2) begin
      n_errors++;
      $display("Error %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge clock);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clock);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = (bvalid === 1'b1);
      r  = bresp;
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(r));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clock);
      ta = arvalid & arready;
      tr = (rvalid === 1'b1);
      d  = rdata;
      r  = rresp;
      @(posedge clock);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk("rdata", e, d);
    chk("rresp", 32'(er), 32'(r));
  endtask

  task automatic fall(output int t);
    @(negedge conversion_ready_n);
    t = tick;
    @(negedge clock);
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    n_errors++;
    $display("Error watchdog expected end seen timeout");
    stop_test();
  end

  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    sync_reset_n = 1'b1;
    raw_result = 24'h000100;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    c0 = cyc;
    @(negedge clock);
    chk("ready_low", 32'h0, 32'(conversion_ready_n));
    @(posedge conversion_ready_n);
    t0 = tick;
    chk_n("por_cycles", POR, cyc - c0);
    rd(adc_seq_pkg::OFS_CTRL, adc_seq_pkg::CTRL_RST, 2'b00);
    wr(adc_seq_pkg::OFS_STATUS, 32'h0, adc_seq_pkg::AXI_SLVERR);
    rd(8'h0c, 32'h0, adc_seq_pkg::AXI_SLVERR);
    for (int m = 0; m < 3; m++) begin
      wr(adc_seq_pkg::OFS_CTRL, 32'h13000 | (m << 8), 2'b00);
      chk("power", 32'(m), 32'(power_mode_select));
    end
    chk("dc_test", 32'h1, 32'(dc_test_valid));
    wr(adc_seq_pkg::OFS_PHASE, 32'h1234, 2'b00);
    chk("phase1", 32'h12, 32'(phase_delay_1));
    wr(adc_seq_pkg::OFS_CTRL, adc_seq_pkg::CTRL_RST, 2'b00);
    chk("mod_wait", 32'h0, 32'(modulator_run));
    $display("test registers done");
    fall(t1);
    chk_n("first_data", 1324, t1 - t0);
    chk("fast1", 32'h1, 32'(fast_filter_sel));
    chk("mod_run", 32'h1, 32'(modulator_run));
    chk("result", 32'h100, 32'(conv_result));
    chk("filt_cont", 32'h0, 32'(filter_reset));
    repeat (7) @(posedge clock);
    @(negedge clock);
    chk("ready_pulse", 32'h0, 32'(conversion_ready_n));
    @(negedge clock);
    chk("ready_end", 32'h1, 32'(conversion_ready_n));
    fall(t2);
    chk_n("second_data", 2348, t2 - t0);
    wr(adc_seq_pkg::OFS_CTRL, 32'h0200, 2'b00);
    fall(t1);
    chk_n("sinc3_data", 3372, t1 - t0);
    chk("fast3", 32'h0, 32'(fast_filter_sel));
    fall(t2);
    chk_n("period_128", 128, t2 - t1);
    $display("test startup done");
    wr(adc_seq_pkg::OFS_CTRL, 32'h10241, 2'b00);
    chk("phase0", 32'h0, 32'(phase_delay_0));
    chk("dc_chop", 32'h0, 32'(dc_test_valid));
    @(posedge clock);
    sync_reset_n <= 1'b0;
    t0 = tick;
    repeat (3) @(posedge clock);
    sync_reset_n <= 1'b1;
    fall(t1);
    chk_n("chop_first", 876, t1 - t0);
    p = chop_polarity;
    @(posedge clock);
    raw_result <= 24'h000300;
    fall(t2);
    chk_n("chop_period", 416, t2 - t1);
    chk("polarity", 32'(!p), 32'(chop_polarity));
    chk("chop_avg", 32'h200, 32'(conv_result));
    chk("filt_chop", 32'h1, 32'(filter_reset));
    wr(adc_seq_pkg::OFS_CTRL, 32'h11241, 2'b00);
    t0 = tick;
    fall(t1);
    chk_n("chop_ratio", 1644, t1 - t0);
    $display("test chop done");
    HOST.frame(adc_seq_pkg::RESET_CMD, 40);
    repeat (REG_WAIT) @(posedge clock);
    rd(adc_seq_pkg::OFS_CTRL, 32'h11241, 2'b00);
    HOST.frame(adc_seq_pkg::RESET_CMD, int'(adc_seq_pkg::FRAME_BITS));
    repeat (REG_WAIT) @(posedge clock);
    chk("ready_cmd", 32'h1, 32'(conversion_ready_n));
    chk("fast_cmd", 32'h1, 32'(fast_filter_sel));
    chk("wait_cmd", 32'h0, 32'(modulator_run));
    rd(adc_seq_pkg::OFS_STATUS, 32'h46, 2'b00);
    rd(adc_seq_pkg::OFS_CTRL, adc_seq_pkg::CTRL_RST, 2'b00);
    $display("test command done");
    wr(adc_seq_pkg::OFS_CTRL, 32'h0201, 2'b00);
    @(posedge clock);
    sync_reset_n <= 1'b0;
    repeat (12) @(posedge clock);
    sync_reset_n <= 1'b1;
    repeat (REG_WAIT) @(posedge clock);
    rd(adc_seq_pkg::OFS_CTRL, adc_seq_pkg::CTRL_RST, 2'b00);
    $display("test pin reset done");
    stop_test();
  end
endmodule
